// file: verilog/gptu_port.v
// three general-purpose ports: wide 8-bit, narrow 2-bit, uart 2-bit
// assumes an AXI4-Lite master and peripheral signals on aclk; pins are asynchronous and pass through gptu_sync
`timescale 1ns/1ns
`include "gptu_defs.vh"
module gptu_port (
  input wire aclk,
  input wire aresetn,
  input wire [15:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] wide_pin_in,
  output wire [7:0] wide_pin_out,
  output wire [7:0] wide_pin_oe,
  input wire [1:0] narrow_pin_in,
  output wire [1:0] narrow_pin_out,
  output wire [1:0] narrow_pin_oe,
  input wire [1:0] uart_pin_in,
  output wire [1:0] uart_pin_out,
  output wire [1:0] uart_pin_oe,
  output wire [1:0] uart_pullup_en,
  input wire divider_out,
  input wire pulse_pattern_a_out,
  input wire pulse_pattern_b_out,
  input wire timer0_ppg_out_a,
  input wire timer0_ppg_out_b,
  input wire timer0_ppg_out_c,
  input wire timer0_ppg_out_d,
  input wire timer0_pwm_out_a,
  input wire timer0_pwm_out_b,
  input wire timer0_pwm_out_c,
  input wire timer0_pwm_out_d,
  input wire [3:0] timer0_pwm_sel,
  input wire serial1_transmit,
  output wire ext_irq_in_a,
  output wire ext_irq_in_b,
  output wire ext_irq_in_c,
  output wire timer_a_in_a,
  output wire timer_a_in_b,
  output wire timer0_count_in_a,
  output wire timer0_count_in_b,
  output wire timer0_count_in_c,
  output wire timer0_count_in_d,
  output wire serial1_receive
);

  // configuration registers
  reg [7:0] wide_port_output_latch_reg;
  reg [7:0] wide_port_direction_reg;
  reg [7:0] wide_port_function_select_reg;
  reg [1:0] narrow_port_output_latch_reg;
  reg [1:0] narrow_port_direction_reg;
  reg [1:0] narrow_port_function_select_reg;
  reg [1:0] uart_port_output_latch_reg;
  reg [1:0] uart_port_direction_reg;
  reg [1:0] uart_port_function_select_reg;
  reg [1:0] uart_port_drive_type_reg;
  reg [1:0] uart_port_pullup_reg;

  // bus state
  reg aw_held_reg;
  reg [13:0] aw_idx_reg;
  reg w_held_reg;
  reg [7:0] w_byte_reg;
  reg w_lane_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;

  // pin side flops
  reg [7:0] wide_out_reg;
  reg [7:0] wide_oe_reg;
  reg [1:0] narrow_out_reg;
  reg [1:0] narrow_oe_reg;
  reg [1:0] uart_out_reg;
  reg [1:0] uart_oe_reg;
  reg [1:0] uart_pu_reg;
  reg [2:0] irq_reg;
  reg [3:0] wide_tin_reg;
  reg [1:0] narrow_tin_reg;
  reg rx_reg;

  wire [11:0] pins_sync;
  wire [7:0] wide_sync;
  wire [1:0] narrow_sync;
  wire [1:0] uart_sync;

  gptu_sync #(
    .W(`GPTU_SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({uart_pin_in, narrow_pin_in, wide_pin_in}),
    .sync_out(pins_sync)
  );

  assign wide_sync = pins_sync[7:0];
  assign narrow_sync = pins_sync[9:8];
  assign uart_sync = pins_sync[11:10];

  // readback values
  wire [7:0] wide_read;
  wire [1:0] narrow_read;
  wire [1:0] uart_read;
  assign wide_read = wide_sync & ~wide_port_direction_reg;
  assign narrow_read = narrow_sync & ~narrow_port_direction_reg;
  assign uart_read = uart_sync &
    (~uart_port_direction_reg | uart_port_drive_type_reg);

  // secondary outputs per pin
  wire [7:0] wide_sec;
  wire [1:0] narrow_sec;
  wire [1:0] uart_sec;
  wire wave_a;
  wire wave_b;
  wire wave_c;
  wire wave_d;
  assign wave_a = timer0_pwm_sel[0] ? timer0_pwm_out_a : timer0_ppg_out_a;
  assign wave_b = timer0_pwm_sel[1] ? timer0_pwm_out_b : timer0_ppg_out_b;
  assign wave_c = timer0_pwm_sel[2] ? timer0_pwm_out_c : timer0_ppg_out_c;
  assign wave_d = timer0_pwm_sel[3] ? timer0_pwm_out_d : timer0_ppg_out_d;
  assign wide_sec = {3'h0, divider_out, pulse_pattern_b_out,
    pulse_pattern_a_out, wave_b, wave_a};
  assign narrow_sec = {wave_d, wave_c};
  assign uart_sec = {serial1_transmit, serial1_transmit};

  // write decode
  wire wr_fire;
  wire wr_hit;
  wire rd_fire;
  wire [13:0] ar_idx;
  reg wr_known;
  reg rd_known;
  reg [7:0] rd_byte;

  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit = wr_fire && wr_known && w_lane_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign ar_idx = s_axi_araddr[15:2];

  always @* begin
    case (aw_idx_reg)
      `GPTU_IDX_WIDE_LATCH,
      `GPTU_IDX_NARROW_LATCH,
      `GPTU_IDX_UART_LATCH,
      `GPTU_IDX_WIDE_READ,
      `GPTU_IDX_NARROW_READ,
      `GPTU_IDX_UART_READ,
      `GPTU_IDX_WIDE_DIR,
      `GPTU_IDX_NARROW_DIR,
      `GPTU_IDX_UART_DIR,
      `GPTU_IDX_UART_PULLUP,
      `GPTU_IDX_WIDE_FUNC,
      `GPTU_IDX_NARROW_FUNC,
      `GPTU_IDX_UART_FUNC,
      `GPTU_IDX_UART_DRIVE: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // read mux, reserved bits read zero
  always @* begin
    rd_known = 1'b1;
    case (ar_idx)
      `GPTU_IDX_WIDE_LATCH: rd_byte = wide_port_output_latch_reg;
      `GPTU_IDX_NARROW_LATCH: rd_byte = {6'h00, narrow_port_output_latch_reg};
      `GPTU_IDX_UART_LATCH: rd_byte = {6'h00, uart_port_output_latch_reg};
      `GPTU_IDX_WIDE_READ: rd_byte = wide_read;
      `GPTU_IDX_NARROW_READ: rd_byte = {6'h00, narrow_read};
      `GPTU_IDX_UART_READ: rd_byte = {6'h00, uart_read};
      `GPTU_IDX_WIDE_DIR: rd_byte = wide_port_direction_reg;
      `GPTU_IDX_NARROW_DIR: rd_byte = {6'h00, narrow_port_direction_reg};
      `GPTU_IDX_UART_DIR: rd_byte = {6'h00, uart_port_direction_reg};
      `GPTU_IDX_UART_PULLUP: rd_byte = {6'h00, uart_port_pullup_reg};
      `GPTU_IDX_WIDE_FUNC: rd_byte = wide_port_function_select_reg;
      `GPTU_IDX_NARROW_FUNC:
        rd_byte = {6'h00, narrow_port_function_select_reg};
      `GPTU_IDX_UART_FUNC: rd_byte = {6'h00, uart_port_function_select_reg};
      `GPTU_IDX_UART_DRIVE: rd_byte = {6'h00, uart_port_drive_type_reg};
      default: begin
        rd_byte = 8'h00;
        rd_known = 1'b0;
      end
    endcase
  end

  // write address and data, taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 14'h0000;
      w_held_reg <= 1'b0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `GPTU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? `GPTU_RESP_OKAY : `GPTU_RESP_DECERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // register writes with per-register masks
  always @(posedge aclk) begin
    if (!aresetn) begin
      wide_port_output_latch_reg <= `GPTU_RST_BYTE;
      wide_port_direction_reg <= `GPTU_RST_BYTE;
      wide_port_function_select_reg <= `GPTU_RST_BYTE;
      narrow_port_output_latch_reg <= 2'h0;
      narrow_port_direction_reg <= 2'h0;
      narrow_port_function_select_reg <= 2'h0;
      uart_port_output_latch_reg <= 2'h0;
      uart_port_direction_reg <= 2'h0;
      uart_port_function_select_reg <= 2'h0;
      uart_port_drive_type_reg <= 2'h0;
      uart_port_pullup_reg <= 2'h0;
    end else if (wr_hit) begin
      case (aw_idx_reg)
        `GPTU_IDX_WIDE_LATCH:
          wide_port_output_latch_reg <= w_byte_reg;
        `GPTU_IDX_WIDE_DIR:
          wide_port_direction_reg <= w_byte_reg;
        `GPTU_IDX_WIDE_FUNC:
          wide_port_function_select_reg <=
            w_byte_reg & `GPTU_MASK_WIDE_FUNC;
        `GPTU_IDX_NARROW_LATCH:
          narrow_port_output_latch_reg <= w_byte_reg[1:0];
        `GPTU_IDX_NARROW_DIR:
          narrow_port_direction_reg <= w_byte_reg[1:0];
        `GPTU_IDX_NARROW_FUNC:
          narrow_port_function_select_reg <= w_byte_reg[1:0];
        `GPTU_IDX_UART_LATCH:
          uart_port_output_latch_reg <= w_byte_reg[1:0];
        `GPTU_IDX_UART_DIR:
          uart_port_direction_reg <= w_byte_reg[1:0];
        `GPTU_IDX_UART_FUNC:
          uart_port_function_select_reg <= w_byte_reg[1:0];
        `GPTU_IDX_UART_DRIVE:
          uart_port_drive_type_reg <= w_byte_reg[1:0];
        `GPTU_IDX_UART_PULLUP:
          uart_port_pullup_reg <= w_byte_reg[1:0];
        default: begin
        end
      endcase
    end
  end

  // read channel, one cycle after address taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `GPTU_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rd_byte};
      rresp_reg <= rd_known ? `GPTU_RESP_OKAY : `GPTU_RESP_DECERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // pin drive
  wire [7:0] wide_out_next;
  wire [1:0] narrow_out_next;
  wire [1:0] uart_out_next;
  wire [1:0] uart_oe_next;
  wire [1:0] uart_pu_next;
  wire [1:0] uart_level;
  wire [1:0] uart_sec_sel;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_wide
      assign wide_out_next[i] =
        (wide_port_direction_reg[i] && wide_port_function_select_reg[i]) ?
        wide_sec[i] : wide_port_output_latch_reg[i];
    end
    for (i = 0; i < 2; i = i + 1) begin : g_two
      assign narrow_out_next[i] =
        (narrow_port_direction_reg[i] &&
         narrow_port_function_select_reg[i]) ?
        narrow_sec[i] : narrow_port_output_latch_reg[i];
      assign uart_sec_sel[i] = uart_port_direction_reg[i] &&
        uart_port_function_select_reg[i];
      assign uart_level[i] = uart_sec_sel[i] ?
        uart_sec[i] : uart_port_output_latch_reg[i];
      assign uart_out_next[i] = uart_level[i] &&
        !uart_port_drive_type_reg[i];
      assign uart_oe_next[i] = uart_port_direction_reg[i] &&
        (!uart_port_drive_type_reg[i] || !uart_level[i]);
      assign uart_pu_next[i] = uart_port_pullup_reg[i] &&
        (!uart_port_direction_reg[i] ||
         uart_port_drive_type_reg[i]);
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      wide_out_reg <= 8'h00;
      wide_oe_reg <= 8'h00;
      narrow_out_reg <= 2'h0;
      narrow_oe_reg <= 2'h0;
      uart_out_reg <= 2'h0;
      uart_oe_reg <= 2'h0;
      uart_pu_reg <= 2'h0;
      irq_reg <= 3'h0;
      wide_tin_reg <= 4'h0;
      narrow_tin_reg <= 2'h0;
      rx_reg <= 1'b0;
    end else begin
      wide_out_reg <= wide_out_next;
      wide_oe_reg <= wide_port_direction_reg;
      narrow_out_reg <= narrow_out_next;
      narrow_oe_reg <= narrow_port_direction_reg;
      uart_out_reg <= uart_out_next;
      uart_oe_reg <= uart_oe_next;
      uart_pu_reg <= uart_pu_next;
      irq_reg <= wide_sync[7:5] & ~wide_port_direction_reg[7:5];
      wide_tin_reg <= wide_sync[3:0] & ~wide_port_direction_reg[3:0];
      narrow_tin_reg <= narrow_sync & ~narrow_port_direction_reg;
      // first input pin carries receive, else the second
      rx_reg <= !uart_port_direction_reg[0] ? uart_sync[0] :
        (!uart_port_direction_reg[1] ? uart_sync[1] : 1'b1);
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  assign wide_pin_out = wide_out_reg;
  assign wide_pin_oe = wide_oe_reg;
  assign narrow_pin_out = narrow_out_reg;
  assign narrow_pin_oe = narrow_oe_reg;
  assign uart_pin_out = uart_out_reg;
  assign uart_pin_oe = uart_oe_reg;
  assign uart_pullup_en = uart_pu_reg;

  assign ext_irq_in_a = irq_reg[0];
  assign ext_irq_in_b = irq_reg[1];
  assign ext_irq_in_c = irq_reg[2];
  assign timer0_count_in_a = wide_tin_reg[0];
  assign timer0_count_in_b = wide_tin_reg[1];
  assign timer_a_in_a = wide_tin_reg[2];
  assign timer_a_in_b = wide_tin_reg[3];
  assign timer0_count_in_c = narrow_tin_reg[0];
  assign timer0_count_in_d = narrow_tin_reg[1];
  assign serial1_receive = rx_reg;

endmodule

// file: verilog/gptu_defs.vh
// register indices, masks, reset values and bus codes for the port block
// assumes an AXI4-Lite byte address where byte address = index * 4
`ifndef GPTU_DEFS_VH
`define GPTU_DEFS_VH

`define GPTU_ADDR_W 16
`define GPTU_IDX_W 14

`define GPTU_IDX_WIDE_LATCH 14'h0007
`define GPTU_IDX_NARROW_LATCH 14'h0008
`define GPTU_IDX_UART_LATCH 14'h0009
`define GPTU_IDX_WIDE_READ 14'h0014
`define GPTU_IDX_NARROW_READ 14'h0015
`define GPTU_IDX_UART_READ 14'h0016
`define GPTU_IDX_WIDE_DIR 14'h0F21
`define GPTU_IDX_NARROW_DIR 14'h0F22
`define GPTU_IDX_UART_DIR 14'h0F23
`define GPTU_IDX_UART_PULLUP 14'h0F30
`define GPTU_IDX_WIDE_FUNC 14'h0F3B
`define GPTU_IDX_NARROW_FUNC 14'h0F3C
`define GPTU_IDX_UART_FUNC 14'h0F3D
`define GPTU_IDX_UART_DRIVE 14'h0F4A

`define GPTU_RST_BYTE 8'h00
`define GPTU_MASK_FULL 8'hFF
`define GPTU_MASK_WIDE_FUNC 8'h1F
`define GPTU_MASK_TWO 8'h03

`define GPTU_RESP_OKAY 2'h0
`define GPTU_RESP_DECERR 2'h3

`define GPTU_WIDE_W 8
`define GPTU_NARROW_W 2
`define GPTU_UART_W 2
`define GPTU_SYNC_W 12

`endif

// file: verilog/gptu_sync.v
// two-flop synchroniser, one chain per bit
// assumes pins change freely with respect to aclk
`timescale 1ns/1ns
module gptu_sync #(
  parameter W = 12
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg stable_reg;
      always @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg <= 1'b0;
          stable_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate
endmodule

// file: sim/gptu_board.sv
// board model: resolves pin levels from block drivers and board sources
// assumes oe high means the block drives; a pull-up lifts a released pin
`timescale 1ns/1ns
module gptu_board (
  input wire [7:0] wide_pin_out,
  input wire [7:0] wide_pin_oe,
  input wire [7:0] wide_ext,
  input wire [1:0] narrow_pin_out,
  input wire [1:0] narrow_pin_oe,
  input wire [1:0] narrow_ext,
  input wire [1:0] uart_pin_out,
  input wire [1:0] uart_pin_oe,
  input wire [1:0] uart_pullup_en,
  input wire [1:0] uart_ext,
  output wire [7:0] wide_pin_in,
  output wire [1:0] narrow_pin_in,
  output wire [1:0] uart_pin_in
);
  assign wide_pin_in = (wide_pin_oe & wide_pin_out) | (~wide_pin_oe & wide_ext);
  assign narrow_pin_in = (narrow_pin_oe & narrow_pin_out) |
    (~narrow_pin_oe & narrow_ext);
  // released uart pin: pull-up or board source
  assign uart_pin_in = (uart_pin_oe & uart_pin_out) |
    (~uart_pin_oe & (uart_pullup_en | uart_ext));
endmodule

// file: sim/gptu_port_sva.sv
// checker for gptu_port: bus answers, read-only bits, pin gating
// assumes it is bound to gptu_port and sees only its ports
`timescale 1ns/1ns
`include "gptu_defs.vh"
module gptu_port_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [15:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] wide_pin_oe,
  input wire [1:0] narrow_pin_oe,
  input wire [1:0] uart_pin_out,
  input wire [1:0] uart_pin_oe,
  input wire [1:0] uart_pullup_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire [13:0] ar_idx = s_axi_araddr[15:2];
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_at(logic [13:0] idx);
    s_axi_arvalid && s_axi_arready && ar_idx == idx;
  endsequence
  wr_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  busy_refuse_a: assert property (!(s_axi_rvalid && s_axi_arready) &&
    !(s_axi_bvalid && (s_axi_awready || s_axi_wready)))
    else $error("request accepted while busy");
  unmapped_rd_a: assert property (ar_at(14'h0001) |=>
    s_axi_rresp == `GPTU_RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wide_func_ro_a: assert property (ar_at(`GPTU_IDX_WIDE_FUNC) |=>
    s_axi_rdata[31:5] == 27'h0) else $error("wide function high bits set");
  narrow_ro_a: assert property (ar_take ##0 (ar_idx inside {
    `GPTU_IDX_NARROW_LATCH, `GPTU_IDX_NARROW_DIR, `GPTU_IDX_NARROW_FUNC,
    `GPTU_IDX_NARROW_READ, `GPTU_IDX_UART_LATCH, `GPTU_IDX_UART_DRIVE}) |=>
    s_axi_rdata[31:2] == 30'h0) else $error("two-bit register high bits set");
  pin_oe_wr_a: assert property ($changed({wide_pin_oe, narrow_pin_oe}) |->
    $past(s_axi_bvalid)) else $error("pin direction moved without write");
  pullup_gate_a: assert property (
    (uart_pullup_en & uart_pin_oe & uart_pin_out) == 2'h0)
    else $error("pull-up on push-pull high pin");
endmodule
bind gptu_port gptu_port_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wide_pin_oe,
  .narrow_pin_oe, .uart_pin_out, .uart_pin_oe, .uart_pullup_en);

// file: sim/gptu_port_tb_top.sv
// self-checking bench for gptu_port: bus tasks, random pin traffic
// assumes gptu_board on the pins and gptu_port_sva bound to the block
`timescale 1ns/1ns
`include "gptu_defs.vh"
module gptu_port_tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  reg [31:0] s_axi_wdata = 32'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [7:0] wide_ext = 8'h00;
  reg [1:0] narrow_ext = 2'h0, uart_ext = 2'h0;
  reg [3:0] ppg = 4'h0, pwm = 4'h0, timer0_pwm_sel = 4'h0;
  reg divider_out = 1'b0, pulse_pattern_a_out = 1'b0;
  reg pulse_pattern_b_out = 1'b0, serial1_transmit = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] wide_pin_in, wide_pin_out, wide_pin_oe;
  wire [1:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe, uart_pin_in;
  wire [1:0] uart_pin_out, uart_pin_oe, uart_pullup_en;
  wire ext_irq_in_a, ext_irq_in_b, ext_irq_in_c, timer_a_in_a, timer_a_in_b;
  wire timer0_count_in_a, timer0_count_in_b, timer0_count_in_c;
  wire timer0_count_in_d, serial1_receive;
  integer err_count = 0, cmp_count = 0, cyc = 0, i;
  reg [31:0] ra, rb, rc, re;
  reg [7:0] wd, wl, wf, nd, nl, nf, ud, ul, uf, uo, up, wi;
  reg [3:0] wave;
  reg [1:0] lvl, oex, flt, upin;
  reg rxe;
  localparam [195:0] IDXS = {`GPTU_IDX_WIDE_LATCH, `GPTU_IDX_NARROW_LATCH,
    `GPTU_IDX_UART_LATCH, `GPTU_IDX_WIDE_READ, `GPTU_IDX_NARROW_READ,
    `GPTU_IDX_UART_READ, `GPTU_IDX_WIDE_DIR, `GPTU_IDX_NARROW_DIR,
    `GPTU_IDX_UART_DIR, `GPTU_IDX_UART_PULLUP, `GPTU_IDX_WIDE_FUNC,
    `GPTU_IDX_NARROW_FUNC, `GPTU_IDX_UART_FUNC, `GPTU_IDX_UART_DRIVE};
  gptu_port DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wide_pin_in, .wide_pin_out, .wide_pin_oe,
    .narrow_pin_in, .narrow_pin_out, .narrow_pin_oe, .uart_pin_in,
    .uart_pin_out, .uart_pin_oe, .uart_pullup_en, .divider_out,
    .pulse_pattern_a_out, .pulse_pattern_b_out,
    .timer0_ppg_out_a(ppg[0]), .timer0_ppg_out_b(ppg[1]),
    .timer0_ppg_out_c(ppg[2]), .timer0_ppg_out_d(ppg[3]),
    .timer0_pwm_out_a(pwm[0]), .timer0_pwm_out_b(pwm[1]),
    .timer0_pwm_out_c(pwm[2]), .timer0_pwm_out_d(pwm[3]),
    .timer0_pwm_sel, .serial1_transmit, .ext_irq_in_a, .ext_irq_in_b,
    .ext_irq_in_c, .timer_a_in_a, .timer_a_in_b, .timer0_count_in_a,
    .timer0_count_in_b, .timer0_count_in_c, .timer0_count_in_d,
    .serial1_receive);
  gptu_board u_board (.wide_pin_out, .wide_pin_oe, .wide_ext,
    .narrow_pin_out, .narrow_pin_oe, .narrow_ext, .uart_pin_out,
    .uart_pin_oe, .uart_pullup_en, .uart_ext, .wide_pin_in, .narrow_pin_in,
    .uart_pin_in);
  always #50 aclk = ~aclk;
  task print_verdict;
    begin
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      err_count = err_count + 1;
      print_verdict;
    end
  end
  task chk_reg(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task chk_pin(input [7:0] got, input [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask
  // pin level a driver puts out: secondary where dir and func, else latch
  function [7:0] drv(input [7:0] d, input [7:0] f, input [7:0] s,
    input [7:0] l);
    drv = (d & f & s) | (~(d & f) & l);
  endfunction
  task wr(input [13:0] idx, input [7:0] d, input [1:0] er);
    reg a_t, w_t, b_t, v_t, done;
    reg [1:0] br;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(negedge aclk);
        a_t = s_axi_awvalid && s_axi_awready;
        w_t = s_axi_wvalid && s_axi_wready;
        b_t = s_axi_bvalid && s_axi_bready;
        v_t = s_axi_bvalid;
        br = s_axi_bresp;
        @(posedge aclk);
        if (a_t) s_axi_awvalid <= 1'b0;
        if (w_t) s_axi_wvalid <= 1'b0;
        s_axi_bready <= v_t && !b_t;
        done = b_t;
      end
      chk_reg({30'h0, br}, {30'h0, er});
    end
  endtask
  task rd(input [13:0] idx, input [31:0] exp, input [1:0] er);
    reg a_t, r_t, done;
    reg [31:0] d;
    reg [1:0] rr;
    integer n, k;
    begin
      @(posedge aclk);
      k = $urandom % 3;
      n = 0;
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(negedge aclk);
        a_t = s_axi_arvalid && s_axi_arready;
        r_t = s_axi_rvalid && s_axi_rready;
        d = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        if (a_t) s_axi_arvalid <= 1'b0;
        if (n == k) s_axi_rready <= 1'b1;
        if (r_t) s_axi_rready <= 1'b0;
        n = n + 1;
        done = r_t;
      end
      chk_reg(d, exp);
      chk_reg({30'h0, rr}, {30'h0, er});
    end
  endtask
  initial begin
    void'($urandom(75762));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 14; i = i + 1) begin
      rd(IDXS[i*14 +: 14], 32'h0, `GPTU_RESP_OKAY);
    end
    rd(14'h0001, 32'h0, `GPTU_RESP_DECERR);
    wr(14'h0001, 8'hFF, `GPTU_RESP_DECERR);
    s_axi_wstrb <= 4'h0;
    wr(`GPTU_IDX_WIDE_LATCH, 8'hA5, `GPTU_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`GPTU_IDX_WIDE_LATCH, 32'h0, `GPTU_RESP_OKAY);
    for (i = 0; i < 24; i = i + 1) begin
      ra = $urandom;
      rb = $urandom;
      rc = $urandom;
      re = $urandom;
      {nd, wf, wl, wd} = ra;
      {ul, ud, nf, nl} = rb;
      {up, uo, uf} = rc[23:0];
      if (i == 0) begin
        {wd, wf, ud, uo, ul, uf} = {40'hFFFFFFFFFF, 8'h00};
      end
      if (i == 1) begin
        {wd, ud, up} = {16'h0000, 8'hFF};
      end
      @(posedge aclk);
      {serial1_transmit, pulse_pattern_b_out, pulse_pattern_a_out} <= re[27:25];
      divider_out <= re[24];
      {timer0_pwm_sel, pwm, ppg} <= re[23:12];
      {uart_ext, narrow_ext, wide_ext} <= re[11:0];
      wr(`GPTU_IDX_WIDE_LATCH, wl, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_WIDE_FUNC, wf, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_WIDE_DIR, wd, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_NARROW_LATCH, nl, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_NARROW_FUNC, nf, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_NARROW_DIR, nd, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_UART_LATCH, ul, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_UART_FUNC, uf, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_UART_DRIVE, uo, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_UART_PULLUP, up, `GPTU_RESP_OKAY);
      wr(`GPTU_IDX_UART_DIR, ud, `GPTU_RESP_OKAY);
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      wave = (re[23:20] & re[19:16]) | (~re[23:20] & re[15:12]);
      wi = re[7:0] & ~wd;
      lvl = drv(ud, uf, {8{re[27]}}, ul) & 8'h03;
      oex = ud[1:0] & ~(uo[1:0] & lvl);
      flt = up[1:0] | re[11:10];
      upin = (ud[1:0] & lvl & (~uo[1:0] | flt)) | (~ud[1:0] & flt);
      rxe = !ud[0] ? upin[0] : (!ud[1] ? upin[1] : 1'b1);
      chk_pin(wide_pin_oe, wd);
      chk_pin(wide_pin_out & wd, wd & drv(wd, wf & `GPTU_MASK_WIDE_FUNC,
        {3'h0, re[24], re[26], re[25], wave[1:0]}, wl));
      chk_pin({6'h0, narrow_pin_oe}, nd & 8'h03);
      chk_pin({6'h0, narrow_pin_out & nd[1:0]},
        nd & 8'h03 & drv(nd, nf, {6'h0, wave[3:2]}, nl));
      chk_pin({6'h0, uart_pin_oe}, {6'h0, oex});
      chk_pin({6'h0, uart_pin_out & oex}, {6'h0, lvl & ~uo[1:0] & oex});
      chk_pin({6'h0, uart_pullup_en}, up & (~ud | uo) & 8'h03);
      chk_pin({ext_irq_in_c, ext_irq_in_b, ext_irq_in_a, timer_a_in_b,
        timer_a_in_a, timer0_count_in_b, timer0_count_in_a, 1'b0},
        {wi[7:5], wi[3:0], 1'b0});
      chk_pin({5'h0, serial1_receive, timer0_count_in_d, timer0_count_in_c},
        {5'h0, rxe, re[9:8] & ~nd[1:0]});
      rd(`GPTU_IDX_WIDE_READ, {24'h0, wi}, `GPTU_RESP_OKAY);
      rd(`GPTU_IDX_NARROW_READ, {30'h0, re[9:8] & ~nd[1:0]},
        `GPTU_RESP_OKAY);
      rd(`GPTU_IDX_UART_READ, {30'h0, upin & (~ud[1:0] | uo[1:0])},
        `GPTU_RESP_OKAY);
      rd(`GPTU_IDX_WIDE_FUNC, {24'h0, wf & 8'h1F}, `GPTU_RESP_OKAY);
      rd(`GPTU_IDX_NARROW_LATCH, {30'h0, nl[1:0]}, `GPTU_RESP_OKAY);
      rd(`GPTU_IDX_WIDE_LATCH, {24'h0, wl}, `GPTU_RESP_OKAY);
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    {uart_ext, narrow_ext, wide_ext} <= 12'h000;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 14; i = i + 1) begin
      rd(IDXS[i*14 +: 14], 32'h0, `GPTU_RESP_OKAY);
    end
    @(negedge aclk);
    chk_pin(wide_pin_oe | wide_pin_out, 8'h00);
    print_verdict;
  end
endmodule
